// *** common/uotg_pkg.sv ***
// Purpose: shared constants and types for the on-the-go status and address block
// Assumes: 125 MHz i_clk, AHB-Lite word access only
// Notes: offsets are byte addresses within the block's window
package uotg_pkg;

	// ==========================================================
	// register offsets (byte addresses, low eight address bits)
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_CLEAR = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;

	// ==========================================================
	// status field positions
	localparam int BIT_ID = 7;
	localparam int BIT_MS = 6;
	localparam int BIT_LS = 5;
	localparam int BIT_ACT = 4;
	localparam int BIT_SV = 3;
	localparam int BIT_SE = 2;
	localparam int BIT_VB = 0;
	localparam logic [7:0] STATUS_MASK = 8'hFD;

	// address and control field positions
	localparam int ADDR_LS_BIT = 7;
	localparam int CTRL_SUSPEND_BIT = 0;
	localparam int CTRL_TIMER_BIT = 1;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [1:0] RST_CTRL = 2'h0;

	// ==========================================================
	// timing
	localparam int CLK_FREQ_MHZ = 125;
	localparam int MS_TIME_US = 1000;
	localparam int MS_CYCLES = MS_TIME_US * CLK_FREQ_MHZ;
	localparam int CNT_W = 17;
	// cycles of learning after reset, covers the two synchroniser stages
	localparam logic [1:0] PRIME_LAST = 2'h3;

	// ==========================================================
	// bus encodings
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		UOTG_BUS_IDLE = 2'b00,
		UOTG_BUS_WR = 2'b01,
		UOTG_BUS_RWAIT = 2'b10,
		UOTG_BUS_RD = 2'b11
	} uotg_bus_st_t;

	typedef enum logic [2:0] {
		UOTG_REG_NONE = 3'b000,
		UOTG_REG_STATUS = 3'b001,
		UOTG_REG_ENABLE = 3'b010,
		UOTG_REG_CLEAR = 3'b011,
		UOTG_REG_ADDR = 3'b100,
		UOTG_REG_CTRL = 3'b101
	} uotg_reg_t;

	// cable-side levels, bundled
	typedef struct packed {
		logic id;
		logic dp;
		logic dm;
		logic sess_end;
		logic sess_valid;
	} uotg_pins_t;

	localparam uotg_pins_t RST_PINS = 5'h00;

endpackage : uotg_pkg

// *** src/uotg_sync.sv ***
// Purpose: two-stage synchroniser for the cable-side levels
// Assumes: pins are asynchronous to i_clk
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module uotg_sync
(
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire uotg_pkg::uotg_pins_t i_pins, // raw pin levels
	output uotg_pkg::uotg_pins_t o_pins // synchronised levels
);
	import uotg_pkg::*;

	typedef struct packed {
		uotg_pins_t s1;
		uotg_pins_t s2;
	} uotg_sync_state_t;

	uotg_sync_state_t r;
	uotg_sync_state_t next_r;

	always_comb
	begin
		next_r.s1 = i_pins;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			r <= {RST_PINS, RST_PINS};
		end
		else
		begin
			r <= next_r;
		end
	end

	assign o_pins = r.s2;

endmodule : uotg_sync

// *** src/uotg_top.sv ***
// Purpose: on-the-go event flags, interrupt and device address behind AHB-Lite
// Assumes: single word transfers; hsize is not checked
// Notes: writes take no wait state, reads take one
// Operation
// - event flags are hardware set, reset low, cleared only by writing one
// - ID input change sets status bit 7
// - expiry of the 1 ms timer sets status bit 6
// - line state stable 1 ms and unlike last stable state sets bit 5
// - D+, D-, ID or VBUS activity while suspended sets bit 4
// - VBUS dropping below session end sets bit 3
// - any change of the session end input sets bit 2
// - any change of the session valid input sets bit 0
// - status bit 1 and bits 31 to 8 always read zero
// - address bit 7 selects low speed for next token when one
// - seven-bit device address in bits 6 to 0, read-write, resets zero
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module uotg_top
#(
	parameter int MS_CYCLES = uotg_pkg::MS_CYCLES // cycles per millisecond
)
(
	input wire logic i_clk, // system clock, 125 MHz
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_hsel, // slave select
	input wire logic [31:0] i_haddr, // byte address
	input wire logic [1:0] i_htrans, // transfer type
	input wire logic i_hwrite, // write when high
	input wire logic [2:0] i_hsize, // transfer size, words only
	input wire logic [31:0] i_hwdata, // write data
	input wire logic i_hready, // bus ready
	output logic [31:0] o_hrdata, // read data
	output logic o_hreadyout, // slave ready
	output logic o_hresp, // always okay
	input wire uotg_pkg::uotg_pins_t i_pins, // cable-side levels, asynchronous
	output logic o_irq, // interrupt, level, active high
	output logic [6:0] o_dev_addr, // device address
	output logic o_low_speed // next token at low speed
);
	import uotg_pkg::*;

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MS_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	// ==========================================================
	// state
	typedef struct packed {
		uotg_bus_st_t bus;
		uotg_reg_t idx;
		logic hready;
		logic [31:0] hrdata;
		logic [7:0] status;
		logic [7:0] enable;
		logic [7:0] addr;
		logic [1:0] ctrl;
		logic irq;
		logic [1:0] primed;
		uotg_pins_t prev;
		logic [CNT_W-1:0] ms_cnt;
		logic [CNT_W-1:0] ls_cnt;
		logic [1:0] ls_last;
		logic [1:0] ls_stable;
	} uotg_state_t;

	localparam uotg_state_t RST_STATE = '{
		bus: UOTG_BUS_IDLE,
		idx: UOTG_REG_NONE,
		hready: 1'b1,
		hrdata: 32'h0000_0000,
		status: RST_STATUS,
		enable: RST_ENABLE,
		addr: RST_ADDR,
		ctrl: RST_CTRL,
		irq: 1'b0,
		primed: 2'h0,
		prev: RST_PINS,
		ms_cnt: CNT_ZERO,
		ls_cnt: CNT_ZERO,
		ls_last: 2'h0,
		ls_stable: 2'h0
	};

	uotg_state_t r;
	uotg_state_t next_r;
	uotg_pins_t pins;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic accept;
	logic [1:0] line_now;

	// ==========================================================
	// helpers
	function automatic uotg_reg_t decode(input logic [31:0] addr);
		uotg_reg_t idx;
		unique case (addr[7:0])
			OFS_STATUS: idx = UOTG_REG_STATUS;
			OFS_ENABLE: idx = UOTG_REG_ENABLE;
			OFS_CLEAR: idx = UOTG_REG_CLEAR;
			OFS_ADDR: idx = UOTG_REG_ADDR;
			OFS_CTRL: idx = UOTG_REG_CTRL;
			default: idx = UOTG_REG_NONE;
		endcase
		// only the lowest 256 bytes are mapped
		if (addr[31:8] != 24'h00_0000)
		begin
			idx = UOTG_REG_NONE;
		end
		return idx;
	endfunction : decode

	function automatic logic [31:0] read_mux(input uotg_reg_t idx, input uotg_state_t s);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (idx)
			UOTG_REG_STATUS: d[7:0] = s.status & STATUS_MASK;
			UOTG_REG_ENABLE: d[7:0] = s.enable;
			UOTG_REG_ADDR: d[7:0] = s.addr;
			UOTG_REG_CTRL: d[1:0] = s.ctrl;
			// clear register is write-only, unmapped reads zero
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction : read_mux

	// ==========================================================
	// pin synchroniser
	uotg_sync u_sync
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_pins(i_pins),
		.o_pins(pins)
	);

	assign accept = i_hsel & i_hready & i_htrans[1];
	assign line_now = {pins.dp, pins.dm};

	// ==========================================================
	// next state
	always_comb
	begin
		next_r = r;
		set_bits = 8'h00;
		clr_bits = 8'h00;

		// ======================================================
		// cable events
		if (r.primed != PRIME_LAST)
		begin
			// synchroniser shows reset levels at first: learn the levels, report nothing
			next_r.primed = r.primed + 2'h1;
			next_r.prev = pins;
			next_r.ls_last = line_now;
			next_r.ls_stable = line_now;
			next_r.ls_cnt = CNT_ZERO;
		end
		else
		begin
			if (pins.id != r.prev.id)
			begin
				set_bits[BIT_ID] = 1'b1;
			end
			if (r.ctrl[CTRL_SUSPEND_BIT] && (pins != r.prev))
			begin
				set_bits[BIT_ACT] = 1'b1;
			end
			if (pins.sess_end && !r.prev.sess_end)
			begin
				set_bits[BIT_SV] = 1'b1;
			end
			if (pins.sess_end != r.prev.sess_end)
			begin
				set_bits[BIT_SE] = 1'b1;
			end
			if (pins.sess_valid != r.prev.sess_valid)
			begin
				set_bits[BIT_VB] = 1'b1;
			end
			next_r.prev = pins;

			// line state must hold a full millisecond before it counts
			if (line_now != r.ls_last)
			begin
				next_r.ls_last = line_now;
				next_r.ls_cnt = CNT_ZERO;
			end
			else if (r.ls_cnt != CNT_LAST)
			begin
				next_r.ls_cnt = r.ls_cnt + 1'b1;
			end
			else if (r.ls_last != r.ls_stable)
			begin
				set_bits[BIT_LS] = 1'b1;
				next_r.ls_stable = r.ls_last;
			end
		end

		// ======================================================
		// millisecond timer, free running while enabled
		if (r.ctrl[CTRL_TIMER_BIT])
		begin
			if (r.ms_cnt == CNT_LAST)
			begin
				next_r.ms_cnt = CNT_ZERO;
				set_bits[BIT_MS] = 1'b1;
			end
			else
			begin
				next_r.ms_cnt = r.ms_cnt + 1'b1;
			end
		end
		else
		begin
			next_r.ms_cnt = CNT_ZERO;
		end

		// ======================================================
		// bus slave
		if (r.bus == UOTG_BUS_WR)
		begin
			unique case (r.idx)
				UOTG_REG_STATUS, UOTG_REG_CLEAR:
				begin
					clr_bits = i_hwdata[7:0] & STATUS_MASK;
				end
				UOTG_REG_ENABLE:
				begin
					next_r.enable = i_hwdata[7:0] & STATUS_MASK;
				end
				UOTG_REG_ADDR:
				begin
					next_r.addr = i_hwdata[7:0];
				end
				UOTG_REG_CTRL:
				begin
					next_r.ctrl = i_hwdata[1:0];
				end
				default:
				begin
					next_r.ctrl = r.ctrl;
				end
			endcase
		end

		unique case (r.bus)
			UOTG_BUS_IDLE, UOTG_BUS_WR, UOTG_BUS_RD:
			begin
				if (accept)
				begin
					next_r.idx = decode(i_haddr);
					next_r.bus = i_hwrite ? UOTG_BUS_WR : UOTG_BUS_RWAIT;
					next_r.hready = i_hwrite;
				end
				else
				begin
					next_r.bus = UOTG_BUS_IDLE;
					next_r.hready = 1'b1;
				end
			end
			UOTG_BUS_RWAIT:
			begin
				// wait state lets a write just before be seen
				next_r.hrdata = read_mux(r.idx, r);
				next_r.bus = UOTG_BUS_RD;
				next_r.hready = 1'b1;
			end
		endcase

		// ======================================================
		// flags: a set in the clearing cycle survives
		next_r.status = ((r.status & ~clr_bits) | set_bits) & STATUS_MASK;
		next_r.irq = |(next_r.status & r.enable);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			r <= RST_STATE;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs
	assign o_hrdata = r.hrdata;
	assign o_hreadyout = r.hready;
	assign o_hresp = HRESP_OKAY;
	assign o_irq = r.irq;
	assign o_dev_addr = r.addr[6:0];
	assign o_low_speed = r.addr[ADDR_LS_BIT];

endmodule : uotg_top

// *** sim/uotg_cable.sv ***
// Purpose: cable-side model, a host or peripheral moving the line levels
// Assumes: levels change just after a rising edge
// Notes: levels are plain logic, never released
`timescale 1ns/1ns
module uotg_cable
(
	input wire logic i_clk, // system clock
	output uotg_pkg::uotg_pins_t o_pins // cable levels
);
	import uotg_pkg::*;

	initial o_pins = RST_PINS;

	// ==========================================================
	// level change
	task automatic drive(input uotg_pins_t v);
		@(posedge i_clk);
		o_pins <= v;
	endtask : drive
endmodule : uotg_cable

// *** sim/uotg_checker.sv ***
// Purpose: port-level assertions for uotg_top
// Assumes: i_hready is tied to o_hreadyout
// Notes: attached by the bind at the foot
`timescale 1ns/1ns
module uotg_checker
#(
	parameter int MS_CYCLES = 20 // millisecond in cycles
)
(
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // reset, active low
	input wire logic i_hsel, // select
	input wire logic [31:0] i_haddr, // address
	input wire logic [1:0] i_htrans, // transfer type
	input wire logic i_hwrite, // write
	input wire logic [31:0] i_hwdata, // write data
	input wire logic i_hready, // ready
	input wire logic [31:0] o_hrdata, // read data
	input wire logic o_hreadyout, // slave ready
	input wire logic o_irq, // interrupt
	input wire logic [6:0] o_dev_addr, // device address
	input wire logic o_low_speed // low speed
);
	import uotg_pkg::*;
	logic ph_wr;
	logic ph_rd;
	logic [7:0] ph_a;
	wire logic take = i_hsel & i_hready & i_htrans[1];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// ==========================================================
	// data phase tracking
	always_ff @(posedge i_clk)
	begin
		ph_wr <= i_rst_n & take & i_hwrite;
		ph_rd <= i_rst_n & take & !i_hwrite;
		ph_a <= i_haddr[7:0];
	end

	// ==========================================================
	// assertions
	a_addr_write: assert property (ph_wr && ph_a == OFS_ADDR |=>
		o_dev_addr == $past(i_hwdata[6:0])) else $error("address not written");
	a_speed_write: assert property (ph_wr && ph_a == OFS_ADDR |=>
		o_low_speed == $past(i_hwdata[7])) else $error("speed bit not written");
	a_addr_hold: assert property (!(ph_wr && ph_a == OFS_ADDR) |=>
		$stable({o_low_speed, o_dev_addr})) else $error("address moved");
	a_addr_read: assert property (ph_rd && ph_a == OFS_ADDR |=>
		o_hrdata == {24'h0, o_low_speed, o_dev_addr}) else $error("address read");
	a_status_zero: assert property (ph_rd && ph_a == OFS_STATUS |=>
		o_hrdata[31:8] == 24'h0 && !o_hrdata[1]) else $error("status spare bits");
	a_rd_wait: assert property (take && !i_hwrite |=>
		!o_hreadyout ##1 o_hreadyout) else $error("read wait wrong");
	a_wr_ready: assert property (take && i_hwrite |=> o_hreadyout)
		else $error("write stalled");
	a_irq_mask: assert property (ph_wr && ph_a == OFS_ENABLE && i_hwdata[7:0] == 8'h0
		|-> ##2 !o_irq) else $error("masked interrupt");
	a_reset_quiet: assert property ($rose(i_rst_n) |->
		!o_irq && o_dev_addr == 7'h0 && !o_low_speed) else $error("reset value");
	a_unmapped: assert property (ph_rd && ph_a > OFS_CTRL |=> o_hrdata == 32'h0)
		else $error("unmapped read");
endmodule : uotg_checker

bind uotg_top uotg_checker #(.MS_CYCLES(MS_CYCLES)) uotg_checker_inst (.i_clk, .i_rst_n,
	.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata,
	.o_hreadyout, .o_irq, .o_dev_addr, .o_low_speed);

// *** sim/tb.sv ***
// Purpose: register-level bench for uotg_top
// Assumes: short millisecond count
// Notes: cable levels come from uotg_cable
`timescale 1ns/1ns
module tb;
	import uotg_pkg::*;
	localparam int MS = 20; // short millisecond keeps the run brief
	logic clk, rst_n, hsel, hwrite, hrdy, irq, ls, resp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [6:0] dev;
	uotg_pins_t pins, pins_w;
	int err_total, n_tests;

	uotg_top #(.MS_CYCLES(MS)) uotg_top_inst (.i_clk(clk), .i_rst_n(rst_n),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(resp), .i_pins(pins_w), .o_irq(irq),
		.o_dev_addr(dev), .o_low_speed(ls));
	uotg_cable uotg_cable_inst (.i_clk(clk), .o_pins(pins_w));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk({31'h0, resp}, {31'h0, HRESP_OKAY});
		chk(hrdata, e);
	endtask : rd

	// one cable event, then status, interrupt and clear
	task automatic ev(input uotg_pins_t p, input int w, input logic [31:0] e);
		uotg_cable_inst.drive(p);
		repeat (w) @(posedge clk);
		rd(OFS_STATUS, e);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_CLEAR, 32'hFF);
	endtask : ev

	task automatic end_sim;
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (3000) @(posedge clk);
		err_total++;
		end_sim;
	end

	// ==========================================================
	// tests
	initial
	begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata, err_total, n_tests} = '0;
		pins = RST_PINS;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_STATUS, 32'h0);
		rd(OFS_ADDR, 32'h0);
		wr(OFS_ADDR, 32'hFFFF_FFD5);
		rd(OFS_ADDR, 32'hD5);
		#1;
		chk({24'h0, ls, dev}, 32'hD5);
		wr(OFS_ADDR, 32'h2A);
		#1;
		chk({24'h0, ls, dev}, 32'h2A);
		wr(8'h40, 32'hFF);
		rd(8'h40, 32'h0);
		pins.id = 1'b1;
		uotg_cable_inst.drive(pins);
		repeat (4) @(posedge clk);
		rd(OFS_STATUS, 32'h80);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_STATUS, 32'h0);
		wr(OFS_CLEAR, 32'h0);
		rd(OFS_STATUS, 32'h80);
		wr(OFS_ENABLE, 32'hFF);
		rd(OFS_ENABLE, 32'hFD);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_ENABLE, 32'hFF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_STATUS, 32'h80);
		rd(OFS_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		pins.sess_valid = 1'b1;
		ev(pins, 4, 32'h01);
		pins.sess_end = 1'b1;
		ev(pins, 4, 32'h0C);
		pins.sess_end = 1'b0;
		ev(pins, 4, 32'h04);
		pins.dp = 1'b1;
		ev(pins, 2 * MS, 32'h20);
		wr(OFS_CTRL, 32'h2);
		repeat (MS + 10) @(posedge clk);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_STATUS, 32'h40);
		wr(OFS_CLEAR, 32'hFF);
		wr(OFS_CTRL, 32'h1);
		pins.id = 1'b0;
		ev(pins, 4, 32'h90);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_ADDR, 32'h0);
		repeat (2 * MS) @(posedge clk);
		rd(OFS_STATUS, 32'h0);
		end_sim;
	end
endmodule : tb
